// ### inc/adc_ctrl_pkg.sv
`default_nettype none
package adc_ctrl_pkg;
	localparam int GROUPS = 8;
	localparam int CHANNELS = 12;
	localparam int GRP_W = 3;
	localparam int CH_W = 4;
	localparam int CONV_W = 12;
	localparam int OFF_W = 13;
	localparam int RES_W = 16;
	localparam int ADDR_W = 12;
	localparam int CTRL_W = 8;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] SINGLE_TRIGGER_REG = 12'h000;
	localparam logic [ADDR_W-1:0] CONTINUOUS_TRIGGER_REG = 12'h004;
	localparam logic [ADDR_W-1:0] GROUP_IRQ_ENABLE_REG = 12'h008;
	localparam logic [ADDR_W-1:0] GROUP_DONE_FLAG_REG = 12'h00c;
	localparam logic [ADDR_W-1:0] BYTE_POINTER_RESET_REG = 12'h010;
	localparam logic [ADDR_W-1:0] UNIT_LOCKSTEP_REG = 12'h014;
	localparam logic [ADDR_W-1:0] GROUP_EXECUTION_STATE_REG = 12'h018;
	localparam logic [ADDR_W-1:0] GROUP_ENTRY_STATE_REG = 12'h01c;
	localparam logic [ADDR_W-1:0] CONVERTER_CONTROL_REG = 12'h020;
	localparam logic [ADDR_W-1:0] CHANNEL_SEQUENCE_BASE = 12'h040;
	localparam logic [ADDR_W-1:0] CHANNEL_EVENT_SELECT_BASE = 12'h080;
	localparam logic [ADDR_W-1:0] CHANNEL_OFFSET_BASE = 12'h0c0;
	localparam logic [ADDR_W-1:0] RESULT_BYTE_BASE = 12'h100;
	localparam logic [ADDR_W-1:0] RESULT_WORD_BASE = 12'h140;

	// Event select layout: low byte then high nibble
	localparam int EVT_LOW_LSB = 0;
	localparam int EVT_LOW_W = 8;
	localparam int EVT_HIGH_LSB = 8;
	localparam int EVT_HIGH_W = 4;
	localparam int LOCKSTEP_BIT = 0;
	localparam int BYTE_W = 8;
	localparam logic [RES_W-1:0] RESULT_RESET = 16'h0000;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic start;
		logic [CH_W-1:0] channel;
		logic [CTRL_W-1:0] setting;
	} conv_req_t;

	typedef struct packed {
		logic done;
		logic [CONV_W-1:0] data;
	} conv_rsp_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_SYNC_WAIT = 4'b0010,
		ST_START = 4'b0100,
		ST_CONVERT = 4'b1000
	} seq_state_t;
endpackage
`default_nettype wire

// ### rtl/adc_group_trigger_result_sync.sv
// Notes on behaviour
// - One single-trigger write gives one trigger.
// - Repeat bit set fires trigger every cycle.
// - Repeat trigger arrives one cycle later.
// - CPU trigger sources are permanently wired.
// - Group finish always sets done flag.
// - Interrupt when enabled done flag set.
// - Flags hold until written one; 0xff clears all.
// - Hardware set beats software clear.
// - Result is 12-bit value plus signed offset.
// - CPU reads low byte then high byte.
// - Pointer reset makes next read low byte.
// - Word window returns full 16 bits directly.
// - Enabled channel finish pulses group event.
// - Several event pulses per group run.
// - Lockstep aligns group0 start across units.
// - Lockstep group0 waits for peer running.
// - Peer running seen two cycles after change.
// - Lone lockstep unit waits forever.
// - Clearing lockstep releases waiting unit immediately.
// - Lowest entered group runs next.
// - Trigger to entered group discarded; last start unenters.
`timescale 1ns/1ps
`default_nettype none
module adc_group_trigger_result_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Register bus
	input wire adc_ctrl_pkg::apb_req_t apb_req,
	output adc_ctrl_pkg::apb_rsp_t apb_rsp,
	// Analog converter
	output adc_ctrl_pkg::conv_req_t conv_req,
	input wire adc_ctrl_pkg::conv_rsp_t conv_rsp,
	// Peer unit lock-step
	input wire logic peer_group0_running,
	output logic group0_running,
	// Events and interrupt
	output logic [adc_ctrl_pkg::GROUPS-1:0] group_event,
	output logic irq
);
	localparam int G = adc_ctrl_pkg::GROUPS;
	localparam int C = adc_ctrl_pkg::CHANNELS;
	localparam int AW = adc_ctrl_pkg::ADDR_W;

	function automatic logic [adc_ctrl_pkg::CH_W-1:0] lowest_bit(input logic [C-1:0] m);
		logic [adc_ctrl_pkg::CH_W-1:0] idx;
		idx = '0;
		for (int i = C - 1; i >= 0; i--) begin
			if (m[i]) begin
				idx = adc_ctrl_pkg::CH_W'(i);
			end
		end
		return idx;
	endfunction

	function automatic logic in_block(input logic [AW-1:0] a, input logic [AW-1:0] base, input int n);
		return (a >= base) && (int'(a) < int'(base) + 4 * n) && (a[1:0] == 2'b00);
	endfunction

	function automatic logic [adc_ctrl_pkg::CH_W-1:0] block_index(input logic [AW-1:0] a,
			input logic [AW-1:0] base);
		logic [AW-1:0] diff;
		diff = a - base;
		return diff[adc_ctrl_pkg::CH_W+1:2];
	endfunction

	// Bus phases
	logic pready_q;
	logic access_done;
	logic wr_en;
	logic rd_en;
	assign access_done = apb_req.psel && apb_req.penable && pready_q;
	assign wr_en = access_done && apb_req.pwrite;
	assign rd_en = access_done && !apb_req.pwrite;

	function automatic logic wr_to(input logic [AW-1:0] a);
		return wr_en && (apb_req.paddr == a);
	endfunction

	logic [adc_ctrl_pkg::CH_W-1:0] acc_idx;
	logic in_seq;
	logic in_evt;
	logic in_off;
	logic in_rbyte;
	logic in_rword;
	always_comb begin
		acc_idx = '0;
		in_seq = in_block(apb_req.paddr, adc_ctrl_pkg::CHANNEL_SEQUENCE_BASE, G);
		in_evt = in_block(apb_req.paddr, adc_ctrl_pkg::CHANNEL_EVENT_SELECT_BASE, G);
		in_off = in_block(apb_req.paddr, adc_ctrl_pkg::CHANNEL_OFFSET_BASE, C);
		in_rbyte = in_block(apb_req.paddr, adc_ctrl_pkg::RESULT_BYTE_BASE, C);
		in_rword = in_block(apb_req.paddr, adc_ctrl_pkg::RESULT_WORD_BASE, C);
		if (in_seq) begin
			acc_idx = block_index(apb_req.paddr, adc_ctrl_pkg::CHANNEL_SEQUENCE_BASE);
		end else if (in_evt) begin
			acc_idx = block_index(apb_req.paddr, adc_ctrl_pkg::CHANNEL_EVENT_SELECT_BASE);
		end else if (in_off) begin
			acc_idx = block_index(apb_req.paddr, adc_ctrl_pkg::CHANNEL_OFFSET_BASE);
		end else if (in_rbyte) begin
			acc_idx = block_index(apb_req.paddr, adc_ctrl_pkg::RESULT_BYTE_BASE);
		end else if (in_rword) begin
			acc_idx = block_index(apb_req.paddr, adc_ctrl_pkg::RESULT_WORD_BASE);
		end
	end

	// Software state
	logic [G-1:0] loop_q;
	logic [G-1:0] ien_q;
	logic [G-1:0] done_q;
	logic [G-1:0] done_d;
	logic lockstep_q;
	logic [adc_ctrl_pkg::CTRL_W-1:0] ctrl_q;
	logic byte_ptr_q;
	logic [C-1:0] seq_q [G];
	logic [C-1:0] evsel_q [G];
	logic [adc_ctrl_pkg::OFF_W-1:0] offset_q [C];
	logic [adc_ctrl_pkg::RES_W-1:0] result_q [C];

	// Sequencer state
	adc_ctrl_pkg::seq_state_t state_q;
	logic [G-1:0] entered_q;
	logic [G-1:0] exec_q;
	logic [adc_ctrl_pkg::GRP_W-1:0] cur_grp_q;
	logic [C-1:0] remain_q;
	logic [adc_ctrl_pkg::CH_W-1:0] cur_ch_q;
	logic peer_meta_q;
	logic peer_run_q;

	// Single write fires on the write edge itself; repeat bits fire from storage
	logic [G-1:0] single_fire;
	logic [G-1:0] trigger;
	assign single_fire = (wr_en && apb_req.paddr == adc_ctrl_pkg::SINGLE_TRIGGER_REG)
		? apb_req.pwdata[G-1:0] : '0;
	assign trigger = single_fire | loop_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			loop_q <= '0;
			ien_q <= '0;
			lockstep_q <= 1'b0;
			ctrl_q <= adc_ctrl_pkg::CTRL_RESET;
		end else begin
			if (wr_to(adc_ctrl_pkg::CONTINUOUS_TRIGGER_REG)) begin
				loop_q <= apb_req.pwdata[G-1:0];
			end
			if (wr_to(adc_ctrl_pkg::GROUP_IRQ_ENABLE_REG)) begin
				ien_q <= apb_req.pwdata[G-1:0];
			end
			if (wr_to(adc_ctrl_pkg::UNIT_LOCKSTEP_REG)) begin
				lockstep_q <= apb_req.pwdata[adc_ctrl_pkg::LOCKSTEP_BIT];
			end
			if (wr_to(adc_ctrl_pkg::CONVERTER_CONTROL_REG)) begin
				ctrl_q <= apb_req.pwdata[adc_ctrl_pkg::CTRL_W-1:0];
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < G; gi++) begin : g_group_cfg
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					seq_q[gi] <= '0;
					evsel_q[gi] <= '0;
				end else if (wr_en && acc_idx == adc_ctrl_pkg::CH_W'(gi)) begin
					if (in_seq) begin
						seq_q[gi] <= apb_req.pwdata[C-1:0];
					end
					if (in_evt) begin
						evsel_q[gi] <= apb_req.pwdata[C-1:0];
					end
				end
			end
		end
		for (gi = 0; gi < C; gi++) begin : g_channel
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					offset_q[gi] <= '0;
				end else if (wr_en && in_off && acc_idx == adc_ctrl_pkg::CH_W'(gi)) begin
					offset_q[gi] <= apb_req.pwdata[adc_ctrl_pkg::OFF_W-1:0];
				end
			end
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					result_q[gi] <= adc_ctrl_pkg::RESULT_RESET;
				end else if (state_q == adc_ctrl_pkg::ST_CONVERT && conv_rsp.done
						&& cur_ch_q == adc_ctrl_pkg::CH_W'(gi)) begin
					result_q[gi] <= adc_ctrl_pkg::RES_W'($signed({4'h0, conv_rsp.data}))
						+ adc_ctrl_pkg::RES_W'($signed(offset_q[gi]));
				end
			end
		end
	endgenerate

	// Byte pointer for CPU reads of the byte window
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			byte_ptr_q <= 1'b0;
		end else if (wr_to(adc_ctrl_pkg::BYTE_POINTER_RESET_REG) && apb_req.pwdata[0]) begin
			byte_ptr_q <= 1'b0;
		end else if (rd_en && in_rbyte) begin
			byte_ptr_q <= !byte_ptr_q;
		end
	end

	// Group finish and flag clear
	logic grp_finish;
	assign grp_finish = (state_q == adc_ctrl_pkg::ST_START && remain_q == '0)
		|| (state_q == adc_ctrl_pkg::ST_CONVERT && conv_rsp.done && remain_q == '0);

	always_comb begin
		done_d = done_q;
		if (wr_to(adc_ctrl_pkg::GROUP_DONE_FLAG_REG)) begin
			done_d = done_q & ~apb_req.pwdata[G-1:0];
		end
		if (grp_finish) begin
			done_d[cur_grp_q] = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			done_q <= '0;
			irq <= 1'b0;
		end else begin
			done_q <= done_d;
			irq <= |(done_q & ien_q);
		end
	end

	// Peer running indication through two flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			peer_meta_q <= 1'b0;
			peer_run_q <= 1'b0;
			group0_running <= 1'b0;
		end else begin
			peer_meta_q <= peer_group0_running;
			peer_run_q <= peer_meta_q;
			group0_running <= exec_q[0];
		end
	end

	// Entry state
	logic [G-1:0] unenter;
	logic [adc_ctrl_pkg::GRP_W-1:0] pick_grp;
	logic [C-1:0] remain_next;
	assign pick_grp = adc_ctrl_pkg::GRP_W'(lowest_bit({{(C-G){1'b0}}, entered_q}));
	assign remain_next = remain_q & ~(C'(1) << lowest_bit(remain_q));

	always_comb begin
		unenter = '0;
		if (state_q == adc_ctrl_pkg::ST_START && remain_next == '0) begin
			unenter[cur_grp_q] = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			entered_q <= '0;
		end else begin
			entered_q <= (entered_q & ~unenter) | (trigger & ~entered_q);
		end
	end

	// Group sequencer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= adc_ctrl_pkg::ST_IDLE;
			exec_q <= '0;
			cur_grp_q <= '0;
			remain_q <= '0;
			cur_ch_q <= '0;
		end else begin
			case (state_q)
				adc_ctrl_pkg::ST_IDLE: begin
					if (entered_q != '0) begin
						cur_grp_q <= pick_grp;
						remain_q <= seq_q[pick_grp];
						exec_q[pick_grp] <= 1'b1;
						if (pick_grp == '0 && lockstep_q) begin
							state_q <= adc_ctrl_pkg::ST_SYNC_WAIT;
						end else begin
							state_q <= adc_ctrl_pkg::ST_START;
						end
					end
				end
				adc_ctrl_pkg::ST_SYNC_WAIT: begin
					if (!lockstep_q || peer_run_q) begin
						state_q <= adc_ctrl_pkg::ST_START;
					end
				end
				adc_ctrl_pkg::ST_START: begin
					if (remain_q == '0) begin
						exec_q[cur_grp_q] <= 1'b0;
						state_q <= adc_ctrl_pkg::ST_IDLE;
					end else begin
						cur_ch_q <= lowest_bit(remain_q);
						remain_q <= remain_next;
						state_q <= adc_ctrl_pkg::ST_CONVERT;
					end
				end
				adc_ctrl_pkg::ST_CONVERT: begin
					if (conv_rsp.done) begin
						if (remain_q == '0) begin
							exec_q[cur_grp_q] <= 1'b0;
							state_q <= adc_ctrl_pkg::ST_IDLE;
						end else begin
							state_q <= adc_ctrl_pkg::ST_START;
						end
					end
				end
				default: begin
					state_q <= adc_ctrl_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Converter request and group events
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			conv_req <= '0;
			group_event <= '0;
		end else begin
			conv_req.start <= state_q == adc_ctrl_pkg::ST_START && remain_q != '0;
			conv_req.channel <= lowest_bit(remain_q);
			conv_req.setting <= ctrl_q;
			group_event <= '0;
			if (state_q == adc_ctrl_pkg::ST_CONVERT && conv_rsp.done && evsel_q[cur_grp_q][cur_ch_q]) begin
				group_event[cur_grp_q] <= 1'b1;
			end
		end
	end

	// Read data and bus answer
	logic [31:0] rd_data;
	logic rd_err;
	always_comb begin
		rd_data = '0;
		rd_err = 1'b0;
		case (apb_req.paddr)
			adc_ctrl_pkg::SINGLE_TRIGGER_REG: rd_data = '0;
			adc_ctrl_pkg::CONTINUOUS_TRIGGER_REG: rd_data[G-1:0] = loop_q;
			adc_ctrl_pkg::GROUP_IRQ_ENABLE_REG: rd_data[G-1:0] = ien_q;
			adc_ctrl_pkg::GROUP_DONE_FLAG_REG: rd_data[G-1:0] = done_q;
			adc_ctrl_pkg::BYTE_POINTER_RESET_REG: rd_data = '0;
			adc_ctrl_pkg::UNIT_LOCKSTEP_REG: rd_data[adc_ctrl_pkg::LOCKSTEP_BIT] = lockstep_q;
			adc_ctrl_pkg::GROUP_EXECUTION_STATE_REG: rd_data[G-1:0] = exec_q;
			adc_ctrl_pkg::GROUP_ENTRY_STATE_REG: rd_data[G-1:0] = entered_q;
			adc_ctrl_pkg::CONVERTER_CONTROL_REG: rd_data[adc_ctrl_pkg::CTRL_W-1:0] = ctrl_q;
			default: begin
				if (in_seq) begin
					rd_data[C-1:0] = seq_q[acc_idx[adc_ctrl_pkg::GRP_W-1:0]];
				end else if (in_evt) begin
					rd_data[C-1:0] = evsel_q[acc_idx[adc_ctrl_pkg::GRP_W-1:0]];
				end else if (in_off) begin
					rd_data[adc_ctrl_pkg::OFF_W-1:0] = offset_q[acc_idx];
				end else if (in_rbyte) begin
					rd_data[adc_ctrl_pkg::BYTE_W-1:0] = byte_ptr_q
						? result_q[acc_idx][adc_ctrl_pkg::RES_W-1:adc_ctrl_pkg::BYTE_W]
						: result_q[acc_idx][adc_ctrl_pkg::BYTE_W-1:0];
				end else if (in_rword) begin
					rd_data[adc_ctrl_pkg::RES_W-1:0] = result_q[acc_idx];
				end else begin
					rd_err = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pready_q <= 1'b0;
			apb_rsp <= '0;
		end else begin
			pready_q <= apb_req.psel && apb_req.penable && !pready_q;
			apb_rsp.pready <= apb_req.psel && apb_req.penable && !pready_q;
			apb_rsp.pslverr <= apb_req.psel && apb_req.penable && !pready_q && rd_err;
			if (apb_req.psel && apb_req.penable && !pready_q && !apb_req.pwrite) begin
				apb_rsp.prdata <= rd_data;
			end
		end
	end
endmodule
`default_nettype wire

// ### verif/adc_group_trigger_result_sync_props.sv
`timescale 1ns/1ps
`default_nettype none
module adc_group_trigger_result_sync_props (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Watched ports
	input wire adc_ctrl_pkg::apb_req_t apb_req,
	input wire adc_ctrl_pkg::apb_rsp_t apb_rsp,
	input wire adc_ctrl_pkg::conv_req_t conv_req,
	input wire adc_ctrl_pkg::conv_rsp_t conv_rsp,
	input wire logic peer_group0_running,
	input wire logic group0_running,
	input wire logic [adc_ctrl_pkg::GROUPS-1:0] group_event,
	input wire logic irq
);
	logic wr;
	logic lock_q;
	logic [7:0] en_q;
	logic [3:0] peer_q;
	assign wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lock_q <= 1'b0;
		end else if (wr && apb_req.paddr == adc_ctrl_pkg::UNIT_LOCKSTEP_REG) begin
			lock_q <= apb_req.pwdata[adc_ctrl_pkg::LOCKSTEP_BIT];
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			en_q <= 8'h00;
		end else if (wr && apb_req.paddr == adc_ctrl_pkg::GROUP_IRQ_ENABLE_REG) begin
			en_q <= apb_req.pwdata[7:0];
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			peer_q <= 4'h0;
		end else begin
			peer_q <= {peer_q[2:0], peer_group0_running};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_pready_timing: assert property ($rose(apb_req.penable) |-> !apb_rsp.pready ##1 apb_rsp.pready)
		else $error("pready not on second access edge");
	a_pready_in_access: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
		else $error("pready outside access");
	a_pslverr_with_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
		else $error("pslverr without pready");
	a_irq_needs_enable: assert property ((en_q == 8'h00) [*2] |-> !irq)
		else $error("irq with no group enabled");
	a_event_after_done: assert property (|group_event |-> $past(conv_rsp.done))
		else $error("event without finished channel");
	a_event_one_line: assert property ($onehot0(group_event))
		else $error("several event lines at once");
	a_lockstep_hold: assert property (lock_q && group0_running && peer_q == 4'h0 |-> !conv_req.start)
		else $error("group0 started without peer");
	a_lockstep_release: assert property (lock_q && group0_running && peer_q == 4'h0 ##1 !lock_q
		|-> ##[0:6] conv_req.start)
		else $error("waiting unit not released");
endmodule
bind adc_group_trigger_result_sync adc_group_trigger_result_sync_props i_props (.clk(clk), .reset_n(reset_n),
	.apb_req(apb_req), .apb_rsp(apb_rsp), .conv_req(conv_req), .conv_rsp(conv_rsp),
	.peer_group0_running(peer_group0_running), .group0_running(group0_running),
	.group_event(group_event), .irq(irq));
`default_nettype wire

// ### verif/adc_group_trigger_result_sync_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_group_trigger_result_sync_tb;
	logic clk;
	logic reset_n;
	adc_ctrl_pkg::apb_req_t req;
	adc_ctrl_pkg::apb_rsp_t rsp;
	adc_ctrl_pkg::conv_req_t creq;
	adc_ctrl_pkg::conv_rsp_t crsp;
	logic peer;
	logic g0run;
	logic [7:0] gev;
	logic irq;
	logic [11:0] value;
	logic [1:0] lag;
	logic err;
	int failures = 0;
	int total_checks = 0;
	int ev_n = 0;
	int chs[$];
	adc_group_trigger_result_sync i_dut (.clk(clk), .reset_n(reset_n), .apb_req(req), .apb_rsp(rsp),
		.conv_req(creq), .conv_rsp(crsp), .peer_group0_running(peer), .group0_running(g0run),
		.group_event(gev), .irq(irq));
	conv_model i_conv (.clk(clk), .req(creq), .rsp(crsp), .value(value), .lag(lag));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		ev_n <= ev_n + $countones(gev);
		if (creq.start) begin
			chs.push_back(int'(creq.channel));
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		q = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
		// Idle cycle so the next setup never reassigns req in this time step
		@(posedge clk);
		if (n >= 20) begin
			failures++;
			complete_run();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		apb(1'b0, a, 32'h0, q);
	endtask
	task automatic wait_flag(input logic [7:0] m);
		logic [31:0] q;
		int n;
		n = 0;
		do begin
			rd(adc_ctrl_pkg::GROUP_DONE_FLAG_REG, q);
			n++;
		end while ((q[7:0] & m) !== m && n < 100);
		chk(q[7:0] & m, m);
		if (n >= 100) begin
			complete_run();
		end
	endtask
	function automatic logic [15:0] sum16(input logic [11:0] v, input logic [12:0] o);
		return {4'h0, v} + {{3{o[12]}}, o};
	endfunction
	initial begin
		logic [31:0] q;
		logic [15:0] e;
		logic [12:0] o;
		int g;
		int c1;
		int c2;
		int n;
		reset_n = 1'b0;
		req = '0;
		peer = 1'b0;
		value = 12'h000;
		lag = 2'h0;
		void'($urandom(68545));
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rd(adc_ctrl_pkg::GROUP_DONE_FLAG_REG, q);
		chk(q, 32'h0);
		rd(adc_ctrl_pkg::SINGLE_TRIGGER_REG, q);
		chk(q, 32'h0);
		rd(12'hffc, q);
		chk(err, 1'b1);
		// Control written only while nothing converts
		e = 16'($urandom);
		wr(adc_ctrl_pkg::CONVERTER_CONTROL_REG, 32'(e[7:0]));
		rd(adc_ctrl_pkg::CONVERTER_CONTROL_REG, q);
		chk(q[7:0], e[7:0]);
		chk(creq.setting, e[7:0]);
		$display("test registers done");
		// Two channels, second offset at its most negative
		g = $urandom_range(7, 1);
		c1 = $urandom_range(5, 0);
		c2 = $urandom_range(11, 6);
		value <= 12'($urandom);
		lag <= 2'($urandom);
		o = 13'($urandom);
		wr(adc_ctrl_pkg::CHANNEL_OFFSET_BASE + 12'(4 * c1), 32'(o));
		wr(adc_ctrl_pkg::CHANNEL_OFFSET_BASE + 12'(4 * c2), 32'h1000);
		wr(adc_ctrl_pkg::CHANNEL_SEQUENCE_BASE + 12'(4 * g), (32'h1 << c1) | (32'h1 << c2));
		wr(adc_ctrl_pkg::CHANNEL_EVENT_SELECT_BASE + 12'(4 * g), (32'h1 << c1) | (32'h1 << c2));
		n = ev_n;
		chs.delete();
		wr(adc_ctrl_pkg::SINGLE_TRIGGER_REG, 32'h1 << g);
		wait_flag(8'(1 << g));
		repeat (20) @(posedge clk);
		chk(chs.size(), 2);
		chk(ev_n - n, 2);
		rd(adc_ctrl_pkg::RESULT_WORD_BASE + 12'(4 * c2), q);
		chk(q[15:0], sum16(value, 13'h1000));
		e = sum16(value, o);
		rd(adc_ctrl_pkg::RESULT_BYTE_BASE + 12'(4 * c1), q);
		chk(q[7:0], e[7:0]);
		rd(adc_ctrl_pkg::RESULT_BYTE_BASE + 12'(4 * c1), q);
		chk(q[7:0], e[15:8]);
		wr(adc_ctrl_pkg::BYTE_POINTER_RESET_REG, 32'h1);
		rd(adc_ctrl_pkg::RESULT_BYTE_BASE + 12'(4 * c1), q);
		chk(q[7:0], e[7:0]);
		$display("test result path done");
		chk(irq, 1'b0);
		wr(adc_ctrl_pkg::GROUP_IRQ_ENABLE_REG, 32'h1 << g);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		wr(adc_ctrl_pkg::GROUP_DONE_FLAG_REG, ~(32'h1 << g) & 32'hff);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		wr(adc_ctrl_pkg::GROUP_DONE_FLAG_REG, 32'hff);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		$display("test interrupt done");
		chs.delete();
		wr(adc_ctrl_pkg::CONTINUOUS_TRIGGER_REG, 32'h1 << g);
		repeat (80) @(posedge clk);
		chk(chs.size() >= 4, 1'b1);
		wr(adc_ctrl_pkg::CONTINUOUS_TRIGGER_REG, 32'h0);
		repeat (30) @(posedge clk);
		n = chs.size();
		repeat (40) @(posedge clk);
		chk(chs.size(), n);
		$display("test continuous done");
		wr(adc_ctrl_pkg::CHANNEL_SEQUENCE_BASE + 12'h004, 32'h1);
		wr(adc_ctrl_pkg::CHANNEL_SEQUENCE_BASE + 12'h018, 32'h800);
		wr(adc_ctrl_pkg::GROUP_DONE_FLAG_REG, 32'hff);
		chs.delete();
		wr(adc_ctrl_pkg::SINGLE_TRIGGER_REG, 32'h42);
		wait_flag(8'h42);
		chk(chs[0], 0);
		chk(chs[1], 11);
		$display("test priority done");
		wr(adc_ctrl_pkg::CHANNEL_SEQUENCE_BASE, 32'h20);
		for (int k = 0; k < 2; k++) begin
			wr(adc_ctrl_pkg::GROUP_DONE_FLAG_REG, 32'hff);
			wr(adc_ctrl_pkg::UNIT_LOCKSTEP_REG, 32'h1);
			chs.delete();
			wr(adc_ctrl_pkg::SINGLE_TRIGGER_REG, 32'h1);
			repeat (30) @(posedge clk);
			chk(chs.size(), 0);
			chk(g0run, 1'b1);
			if (k == 0) begin
				wr(adc_ctrl_pkg::UNIT_LOCKSTEP_REG, 32'h0);
			end else begin
				peer <= 1'b1;
			end
			repeat (15) @(posedge clk);
			chk(chs.size(), 1);
			wait_flag(8'h01);
			peer <= 1'b0;
		end
		$display("test lockstep done");
		complete_run();
	end
endmodule
`default_nettype wire

// ### verif/conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module conv_model (
	// Clock
	input wire logic clk,
	// Converter link
	input wire adc_ctrl_pkg::conv_req_t req,
	output adc_ctrl_pkg::conv_rsp_t rsp,
	// Bench control
	input wire logic [11:0] value,
	input wire logic [1:0] lag
);
	logic [2:0] cnt_q = 3'h0;
	logic [11:0] last_q = 12'h000;
	initial rsp = '0;
	// Data outside done shows the inverse of the last value
	always @(posedge clk) begin
		rsp.done <= 1'b0;
		rsp.data <= ~last_q;
		if (req.start) begin
			cnt_q <= {1'b0, lag} + 3'h1;
		end else if (cnt_q == 3'h1) begin
			rsp.done <= 1'b1;
			rsp.data <= value;
			last_q <= value;
			cnt_q <= 3'h0;
		end else if (cnt_q != 3'h0) begin
			cnt_q <= cnt_q - 3'h1;
		end
	end
endmodule
`default_nettype wire
